// *** rtl/xdl_pkg.sv ***
package xdl_pkg;
   localparam int unsigned INSN_W = 14;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned FADDR_W = 7;
   localparam int unsigned DIR_SEL_W = 3;
   localparam int unsigned N_DIR = 3;
   // Opcode patterns and direction selector range
   localparam logic [5:0] OPC_XOR_LIT = 6'h3A;
   localparam logic [5:0] OPC_XOR_FILE = 6'h06;
   localparam logic [10:0] OPC_DIR_LOAD = 11'h00C;
   localparam logic [2:0] DIR_SEL_MIN = 3'h5;
   localparam logic [2:0] DIR_SEL_MAX = 3'h7;
   // Field positions
   localparam int unsigned OPC_HI = 13;
   localparam int unsigned OPC_LO = 8;
   localparam int unsigned DEST_BIT = 7;
   localparam int unsigned DIR_OPC_LO = 3;
   // Reset values
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] DIR_RST = 8'hFF;

   typedef struct packed {
      logic valid;
      logic [13:0] word;
   } xdl_insn_t;

   typedef struct packed {
      logic we;
      logic [6:0] addr;
      logic [7:0] data;
   } xdl_fwr_t;

   typedef enum logic [1:0] {
      XDL_OP_NONE,
      XDL_OP_XLIT,
      XDL_OP_XFILE,
      XDL_OP_DIR
   } xdl_op_t;
endpackage

// *** rtl/xdl_exec.sv ***
`timescale 1ns/1ps
module xdl_exec (
   input wire logic i_clk_sys, // Instruction clock
   input wire logic i_rst, // Sync reset, active high
   input wire xdl_pkg::xdl_insn_t i_insn, // Fetched word and its valid
   input wire logic [7:0] i_file_rdata, // Addressed file register contents
   output logic [6:0] o_file_raddr, // File read address
   output xdl_pkg::xdl_fwr_t o_file_wr, // File write-back
   output logic [7:0] o_acc, // Accumulator
   output logic o_zero, // Zero flag
   output logic o_zero_we, // Zero flag updated this cycle
   output logic [23:0] o_port_dir, // Direction registers 5,6,7 low to high
   output logic o_busy // Never asserted: no wait states
);
   logic [7:0] acc_r;
   logic [7:0] acc_nxt;
   logic zero_r;
   logic zero_nxt;
   logic zero_we_r;
   xdl_pkg::xdl_fwr_t fwr_r;
   xdl_pkg::xdl_fwr_t fwr_nxt;
   logic [7:0] dir_r [xdl_pkg::N_DIR];

   function automatic logic is_zero(input logic [7:0] v);
      is_zero = (v == 8'h00);
   endfunction

   // Decode
   wire logic [5:0] opc = i_insn.word[xdl_pkg::OPC_HI:xdl_pkg::OPC_LO];
   wire logic [7:0] imm = i_insn.word[7:0];
   wire logic dest = i_insn.word[xdl_pkg::DEST_BIT];
   wire logic [6:0] faddr = i_insn.word[6:0];
   wire logic [2:0] dsel = i_insn.word[2:0];
   wire logic dir_sel_ok = (dsel >= xdl_pkg::DIR_SEL_MIN) && (dsel <= xdl_pkg::DIR_SEL_MAX);
   wire logic [1:0] dir_idx = 2'(dsel - xdl_pkg::DIR_SEL_MIN);
   wire logic dir_word = i_insn.valid
      && (i_insn.word[xdl_pkg::INSN_W-1:xdl_pkg::DIR_OPC_LO] == xdl_pkg::OPC_DIR_LOAD);

   xdl_pkg::xdl_op_t op;
   assign op = !i_insn.valid ? xdl_pkg::XDL_OP_NONE :
               (opc == xdl_pkg::OPC_XOR_LIT) ? xdl_pkg::XDL_OP_XLIT :
               (opc == xdl_pkg::OPC_XOR_FILE) ? xdl_pkg::XDL_OP_XFILE :
               (dir_word && dir_sel_ok)
                  ? xdl_pkg::XDL_OP_DIR : xdl_pkg::XDL_OP_NONE;

   wire logic [7:0] xlit_res = acc_r ^ imm;
   wire logic [7:0] xfile_res = acc_r ^ i_file_rdata;

   assign o_file_raddr = faddr;

   // Next state
   always_comb begin
      acc_nxt = acc_r;
      zero_nxt = zero_r;
      fwr_nxt = '0;
      unique case (op)
         xdl_pkg::XDL_OP_XLIT: begin
            acc_nxt = xlit_res;
            zero_nxt = is_zero(xlit_res);
         end
         xdl_pkg::XDL_OP_XFILE: begin
            zero_nxt = is_zero(xfile_res);
            if (dest) begin
               fwr_nxt = '{we: 1'b1, addr: faddr, data: xfile_res};
            end else begin
               acc_nxt = xfile_res;
            end
         end
         xdl_pkg::XDL_OP_DIR: begin
         end
         xdl_pkg::XDL_OP_NONE: begin
         end
      endcase
   end

   wire logic zero_we_nxt = (op == xdl_pkg::XDL_OP_XLIT) || (op == xdl_pkg::XDL_OP_XFILE);

   // Core state
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         acc_r <= xdl_pkg::ACC_RST;
         zero_r <= 1'b0;
         zero_we_r <= 1'b0;
         fwr_r <= '0;
      end else begin
         acc_r <= acc_nxt;
         zero_r <= zero_nxt;
         zero_we_r <= zero_we_nxt;
         fwr_r <= fwr_nxt;
      end
   end

   // Direction registers
   always_ff @(posedge i_clk_sys) begin
      for (int i = 0; i < xdl_pkg::N_DIR; i++) begin
         if (i_rst) begin
            dir_r[i] <= xdl_pkg::DIR_RST;
         end else if (op == xdl_pkg::XDL_OP_DIR && dir_idx == 2'(i)) begin
            dir_r[i] <= acc_r;
         end
      end
   end

   // Outputs
   assign o_acc = acc_r;
   assign o_zero = zero_r;
   assign o_zero_we = zero_we_r;
   assign o_file_wr = fwr_r;
   assign o_port_dir = {dir_r[2], dir_r[1], dir_r[0]};
   assign o_busy = 1'b0;

   // Checks
   property p_xlit;
      @(posedge i_clk_sys) disable iff (i_rst)
      op == xdl_pkg::XDL_OP_XLIT |=> acc_r == ($past(acc_r) ^ $past(imm)) && zero_r == (acc_r == 8'h00);
   endproperty
   a_xlit: assert property (p_xlit) else $error("literal xor wrong");

   property p_xlit_nofile;
      @(posedge i_clk_sys) disable iff (i_rst)
      op == xdl_pkg::XDL_OP_XLIT |=> !o_file_wr.we && o_zero_we;
   endproperty
   a_xlit_nofile: assert property (p_xlit_nofile) else $error("literal xor side effect");

   property p_dir;
      @(posedge i_clk_sys) disable iff (i_rst)
      op == xdl_pkg::XDL_OP_DIR |=> dir_r[$past(dir_idx)] == $past(acc_r) && $stable(zero_r) && $stable(acc_r);
   endproperty
   a_dir: assert property (p_dir) else $error("direction load wrong");

   property p_dir_hold;
      @(posedge i_clk_sys) disable iff (i_rst)
      op != xdl_pkg::XDL_OP_DIR |=> $stable(o_port_dir);
   endproperty
   a_dir_hold: assert property (p_dir_hold) else $error("direction changed unasked");

   property p_xfile_z;
      @(posedge i_clk_sys) disable iff (i_rst)
      op == xdl_pkg::XDL_OP_XFILE |=> zero_r == (($past(acc_r) ^ $past(i_file_rdata)) == 8'h00);
   endproperty
   a_xfile_z: assert property (p_xfile_z) else $error("file xor zero wrong");

   property p_xfile_w;
      @(posedge i_clk_sys) disable iff (i_rst)
      op == xdl_pkg::XDL_OP_XFILE && !dest |=> acc_r == ($past(acc_r) ^ $past(i_file_rdata)) && !o_file_wr.we;
   endproperty
   a_xfile_w: assert property (p_xfile_w) else $error("file xor to acc wrong");

   property p_xfile_f;
      @(posedge i_clk_sys) disable iff (i_rst)
      op == xdl_pkg::XDL_OP_XFILE && dest |=> o_file_wr.we && o_file_wr.addr == $past(faddr)
         && o_file_wr.data == ($past(acc_r) ^ $past(i_file_rdata)) && $stable(acc_r);
   endproperty
   a_xfile_f: assert property (p_xfile_f) else $error("file xor write-back wrong");

   property p_one_cycle;
      @(posedge i_clk_sys) disable iff (i_rst)
      op == xdl_pkg::XDL_OP_NONE |=> $stable(acc_r) && !o_file_wr.we && !o_zero_we && !o_busy;
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("idle cycle changed state");

   property p_dir_bad;
      @(posedge i_clk_sys) disable iff (i_rst)
      dir_word && !dir_sel_ok |=> $stable(o_port_dir) && $stable(acc_r) && $stable(o_zero)
         && !o_zero_we && !o_file_wr.we;
   endproperty
   a_dir_bad: assert property (p_dir_bad) else $error("refused direction operand acted");

   property p_dir_noflag;
      @(posedge i_clk_sys) disable iff (i_rst)
      op == xdl_pkg::XDL_OP_DIR |=> !o_zero_we && !o_file_wr.we && $stable(o_zero);
   endproperty
   a_dir_noflag: assert property (p_dir_noflag) else $error("direction load touched flags");

   property p_dir_other;
      @(posedge i_clk_sys) disable iff (i_rst)
      op == xdl_pkg::XDL_OP_DIR |=> ($past(dir_idx) == 2'h0 || $stable(dir_r[0]))
         && ($past(dir_idx) == 2'h1 || $stable(dir_r[1])) && ($past(dir_idx) == 2'h2 || $stable(dir_r[2]));
   endproperty
   a_dir_other: assert property (p_dir_other) else $error("wrong direction slot written");

   property p_xfile_zwe;
      @(posedge i_clk_sys) disable iff (i_rst)
      op == xdl_pkg::XDL_OP_XFILE |=> o_zero_we && (o_file_wr.we == $past(dest));
   endproperty
   a_xfile_zwe: assert property (p_xfile_zwe) else $error("file xor flag update wrong");

   property p_zero_hold;
      @(posedge i_clk_sys) disable iff (i_rst)
      !o_zero_we |-> $stable(o_zero);
   endproperty
   a_zero_hold: assert property (p_zero_hold) else $error("zero flag moved without update");

   property p_zwe_src;
      @(posedge i_clk_sys) disable iff (i_rst)
      o_zero_we |-> ($past(op) == xdl_pkg::XDL_OP_XLIT) || ($past(op) == xdl_pkg::XDL_OP_XFILE);
   endproperty
   a_zwe_src: assert property (p_zwe_src) else $error("zero update without xor");

   property p_fwr_src;
      @(posedge i_clk_sys) disable iff (i_rst)
      o_file_wr.we |-> ($past(op) == xdl_pkg::XDL_OP_XFILE) && $past(dest);
   endproperty
   a_fwr_src: assert property (p_fwr_src) else $error("file write without file xor");

   property p_acc_src;
      @(posedge i_clk_sys) disable iff (i_rst)
      $changed(acc_r) |-> ($past(op) == xdl_pkg::XDL_OP_XLIT)
         || (($past(op) == xdl_pkg::XDL_OP_XFILE) && !$past(dest));
   endproperty
   a_acc_src: assert property (p_acc_src) else $error("accumulator changed unasked");

   c_xlit: cover property (@(posedge i_clk_sys) op == xdl_pkg::XDL_OP_XLIT ##1 o_zero);
   c_b2b: cover property (@(posedge i_clk_sys) op == xdl_pkg::XDL_OP_XLIT ##1 op == xdl_pkg::XDL_OP_XLIT);
   c_dir_bad: cover property (@(posedge i_clk_sys) dir_word && !dir_sel_ok);
   c_xfile_f: cover property (@(posedge i_clk_sys) op == xdl_pkg::XDL_OP_XFILE && dest);
   c_dir7: cover property (@(posedge i_clk_sys) op == xdl_pkg::XDL_OP_DIR && dsel == 3'h7);
endmodule

// *** dv/xor_and_dir_load_exec_bench.sv ***
`timescale 1ns/1ps
module xor_and_dir_load_exec_bench;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   xdl_pkg::xdl_insn_t i_insn = '0;
   logic [7:0] i_file_rdata = 8'h00;
   logic [6:0] o_file_raddr;
   xdl_pkg::xdl_fwr_t o_file_wr;
   logic [7:0] o_acc;
   logic o_zero;
   logic o_zero_we;
   logic [23:0] o_port_dir;
   logic o_busy;
   logic [7:0] acc_m;
   logic [23:0] dir_m;
   int err_count = 0;
   int samples_checked = 0;
   xdl_exec dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_insn(i_insn), .i_file_rdata(i_file_rdata),
      .o_file_raddr(o_file_raddr), .o_file_wr(o_file_wr), .o_acc(o_acc), .o_zero(o_zero),
      .o_zero_we(o_zero_we), .o_port_dir(o_port_dir), .o_busy(o_busy));
   initial begin
      forever #25 i_clk_sys = ~i_clk_sys;
   end
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Present one word for one cycle, then settle past the taking edge
   task automatic run(input logic [13:0] word, input logic [7:0] fdata);
      @(posedge i_clk_sys);
      i_insn <= {1'b1, word};
      i_file_rdata <= fdata;
      #1;
      check("raddr", o_file_raddr, word[6:0]);
      @(posedge i_clk_sys);
      i_insn <= '0;
      #1;
      check("busy", o_busy, 1'b0);
   endtask
   task automatic lit(input logic [7:0] k);
      acc_m = acc_m ^ k;
      run({6'h3A, k}, 8'h00);
      check("acc", o_acc, acc_m);
      check("zero", o_zero, acc_m == 8'h00);
      check("zero_we", o_zero_we, 1'b1);
   endtask
   task automatic t_lit();
      lit(8'hB5);
      lit(8'hAF);
      lit(8'h1A);
      @(posedge i_clk_sys);
      #1;
      check("zero_we pulse", o_zero_we, 1'b0);
      $display("literal xor done");
   endtask
   task automatic t_file();
      lit(8'hB5);
      run({6'h06, 1'b1, 7'h7F}, 8'hAF);
      check("file_wr", o_file_wr, {1'b1, 7'h7F, 8'h1A});
      check("acc kept", o_acc, 8'hB5);
      check("zero_we", o_zero_we, 1'b1);
      run({6'h06, 1'b0, 7'h00}, 8'hB5);
      acc_m = 8'h00;
      check("acc", o_acc, 8'h00);
      check("zero", o_zero, 1'b1);
      check("no write", o_file_wr.we, 1'b0);
      $display("file xor done");
   endtask
   task automatic t_dir();
      for (int s = 4; s <= 7; s++) begin
         lit(8'h11 * s[7:0] ^ acc_m);
         run({11'h00C, s[2:0]}, 8'h00);
         if (s >= 5) begin
            dir_m[(s - 5) * 8 +: 8] = acc_m;
         end
         check("port_dir", o_port_dir, dir_m);
         check("flag untouched", {o_zero_we, o_zero}, {1'b0, acc_m == 8'h00});
      end
      $display("direction load done");
   endtask
   task automatic t_b2b();
      @(posedge i_clk_sys);
      i_insn <= {1'b1, 6'h3A, 8'h0F};
      @(posedge i_clk_sys);
      i_insn <= {1'b1, 6'h3A, 8'hF0};
      #1;
      check("acc b2b1", o_acc, acc_m ^ 8'h0F);
      @(posedge i_clk_sys);
      i_insn <= {1'b1, 14'h2000};
      #1;
      acc_m = acc_m ^ 8'hFF;
      check("acc b2b2", o_acc, acc_m);
      @(posedge i_clk_sys);
      i_insn <= '0;
      #1;
      check("acc other word", o_acc, acc_m);
      check("zero_we other word", o_zero_we, 1'b0);
      $display("back to back done");
   endtask
   task automatic t_rst();
      @(posedge i_clk_sys);
      i_rst <= 1'b1;
      i_insn <= {1'b1, 6'h3A, 8'h55};
      @(posedge i_clk_sys);
      i_insn <= '0;
      repeat (2) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      #1;
      acc_m = 8'h00;
      dir_m = 24'hFFFFFF;
      check("reset again", {o_acc, o_zero, o_zero_we, o_file_wr.we}, 11'h000);
      check("reset again dir", o_port_dir, dir_m);
      lit(8'h3C);
      $display("mid-run reset done");
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      acc_m = 8'h00;
      dir_m = 24'hFFFFFF;
      repeat (12) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      #1;
      check("reset", {o_acc, o_zero, o_zero_we, o_file_wr.we}, 11'h000);
      check("reset dir", o_port_dir, dir_m);
      t_lit();
      t_file();
      t_dir();
      t_b2b();
      t_rst();
      summarize();
   end
endmodule
